//--- design/tsc_pkg.sv
`default_nettype none
package tsc_pkg;
  // Register offsets
  localparam logic [7:0] OFS_STATUS_ONE = 8'h14;
  localparam logic [7:0] OFS_STATUS_TWO = 8'h18;
  localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h1C;
  localparam logic [7:0] OFS_RISE_TIME = 8'h20;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  // Reset values
  localparam logic [15:0] RST_CLOCK_CONTROL = 16'h0000;
  localparam logic [5:0] RST_RISE_TIME = 6'h02;
  // Control register fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_HOST_TYPE = 3;
  localparam int CTL_RESOLVE = 4;
  localparam int CTL_PEC_EN = 5;
  localparam int CTL_GC_EN = 6;
  localparam int CTL_NO_STRETCH = 7;
  localparam int CTL_WIDTH = 8;
  // Status one fields
  localparam int S1_START = 0;
  localparam int S1_ADDR = 1;
  localparam int S1_FINISHED = 2;
  localparam int S1_HEADER = 3;
  localparam int S1_TX_EMPTY = 7;
  localparam int S1_RX_FULL = 6;
  // Status two fields
  localparam int S2_MASTER = 0;
  localparam int S2_BUSY = 1;
  localparam int S2_DIR = 2;
  localparam int S2_GCALL = 4;
  localparam int S2_DEFAULT = 5;
  localparam int S2_HOST = 6;
  localparam int S2_DUAL = 7;
  localparam int S2_PEC_LSB = 8;
  // Clock control fields
  localparam int CC_FAST = 15;
  localparam int CC_DUTY = 14;
  localparam int CC_DIV_W = 12;
  localparam int RISE_W = 6;
  // Multipliers for the standard, fast and fast duty modes
  localparam logic [4:0] MUL_ONE = 5'h01;
  localparam logic [4:0] MUL_TWO = 5'h02;
  localparam logic [4:0] MUL_HIGH_DUTY = 5'h09;
  localparam logic [4:0] MUL_LOW_DUTY = 5'h10;
  typedef enum logic [1:0] {
    TSC_IDLE = 2'b00,
    TSC_LOW = 2'b01,
    TSC_RISE = 2'b11,
    TSC_HIGH = 2'b10
  } tsc_scl_e;
endpackage
`default_nettype wire

//--- design/tsc_core.sv
`default_nettype none
// How it works
// R1: Header flag after 10-bit first byte, cleared
// R2: Finished flag on stalled transfer with stretching
// R3: Finished flag cleared by data access
// R4: No finished flag after NACK or PEC
// R5: Address flag cleared by status reads
// R6: Slave sets address flag on recognised address
// R7: Master sets address flag after address ACK
// R8: Status-two read after status-one clears address
// R9: Start flag set on start, cleared
// R10: Packet check byte in status two upper
// R11: Dual flag tells which own address
// R12: Host, default, general call kind flags
// R13: Kind flags cleared on stop, restart, disable
// R14: Direction from address bit, cleared on stop
// R15: Busy on low line, cleared by stop
// R16: Master flag on start, cleared on stop
// R17: Speed bit and duty pick ratio
// R18: SCL periods from divider times multipliers
// R19: Software keeps divider at legal minimum
// R20: Clock registers written only while disabled; the core accepts clock control and rise-time writes at any time
// R21: Rise-time field bounds SCL feedback wait
// R22: Peripheral clock fast enough for rates
// R23: Empty and full flags outside address phase
// R24: High count starts once SCL seen high
// R25: Reserved bits read zero
module tsc_core
  import tsc_pkg::*;
(
  input wire logic clk, // 50 MHz clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic [7:0] addr, // Register byte address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after rd
  input wire logic scl_in, // SCL pin level
  input wire logic sda_in, // SDA pin level
  output logic scl_out, // SCL drive value (always low)
  output logic scl_oe, // SCL driven low while high
  input wire logic ev_start_gen, // Engine made a start condition
  input wire logic ev_start_seen, // Start or repeated start seen
  input wire logic ev_stop_seen, // Stop seen on bus
  input wire logic ev_arb_lost, // Arbitration lost
  input wire logic ev_header_sent, // 10-bit header sent with ACK
  input wire logic ev_addr_done, // Master address phase acked
  input wire logic ev_addr_match, // Slave address recognised
  input wire logic [2:0] match_kind, // 0 own1 1 own2 2 gc 3 default 4 host
  input wire logic rw_bit, // Read/write bit of address
  input wire logic ev_byte_rx, // Byte received with ACK
  input wire logic ev_byte_due, // Next byte due for sending
  input wire logic ev_nack, // NACK received
  input wire logic pec_next, // Next byte is packet check
  input wire logic [7:0] pec_value, // Computed packet check byte
  input wire logic scl_run, // Master clock wanted
  output logic tx_empty, // Data register empty in transmit
  output logic rx_full, // Data register holds received byte
  output logic finished, // Transfer finished flag
  output logic [15:0] status_one_q, // Status one image
  output logic [15:0] status_two_q // Status two image
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
    end else if (ce) begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
    end
  end
  wire logic scl_h = scl_s[1];
  wire logic sda_h = sda_s[1];

  // ****************************************
  // Registers
  // ****************************************
  logic [CTL_WIDTH-1:0] ctl;
  logic [15:0] clk_ctl;
  logic [RISE_W-1:0] rise;
  logic s1_read;
  wire logic en = ctl[CTL_ENABLE];
  wire logic wr_data = wr && addr == OFS_DATA;
  wire logic rd_data = rd && addr == OFS_DATA;
  wire logic rd_s1 = rd && addr == OFS_STATUS_ONE;
  wire logic rd_s2 = rd && addr == OFS_STATUS_TWO;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctl <= '0;
      clk_ctl <= RST_CLOCK_CONTROL;
      rise <= RST_RISE_TIME;
    end else if (ce && wr) begin
      if (addr == OFS_CONTROL) begin
        ctl <= wdata[CTL_WIDTH-1:0];
      end else if (addr == OFS_CLOCK_CONTROL) begin
        clk_ctl <= {wdata[CC_FAST], wdata[CC_DUTY], 2'b00, wdata[CC_DIV_W-1:0]}; // R25 R20
      end else if (addr == OFS_RISE_TIME) begin
        rise <= wdata[RISE_W-1:0]; // R21
      end
    end
  end

  // Status one read arms the two-step clears; any other access ends it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_read <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        s1_read <= 1'b0;
      end else if (rd_s1) begin
        s1_read <= 1'b1;
      end else if (rd || wr) begin
        s1_read <= 1'b0;
      end
    end
  end

  // ****************************************
  // Status one flags
  // ****************************************
  logic start_f;
  logic addr_f;
  logic header_f;
  logic in_addr;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      start_f <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        start_f <= 1'b0;
      end else if (ev_start_gen) begin
        start_f <= 1'b1; // R9
      end else if (s1_read && wr_data) begin
        start_f <= 1'b0; // R9
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      header_f <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        header_f <= 1'b0;
      end else if (ev_header_sent && !ev_nack) begin
        header_f <= 1'b1; // R1
      end else if (s1_read && wr_data) begin
        header_f <= 1'b0; // R1
      end
    end
  end

  // Set wins over the clear in the same cycle; a set between the two reads is still cleared
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_f <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        addr_f <= 1'b0; // R5
      end else if ((ev_addr_done && !ev_nack) || ev_addr_match) begin
        addr_f <= 1'b1; // R6 R7
      end else if (s1_read && rd_s2) begin
        addr_f <= 1'b0; // R5 R8
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_addr <= 1'b0;
    end else if (ce) begin
      if (!en || ev_addr_done || ev_addr_match || ev_stop_seen) begin
        in_addr <= 1'b0;
      end else if (ev_start_seen) begin
        in_addr <= 1'b1;
      end
    end
  end

  // ****************************************
  // Data register flags
  // ****************************************
  logic dir_f;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_empty <= 1'b0;
      rx_full <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        tx_empty <= 1'b0;
        rx_full <= 1'b0;
      end else begin
        if (ev_start_seen || ev_stop_seen || ev_nack) begin
          tx_empty <= 1'b0;
        end else if (dir_f && ev_byte_due && !in_addr && !pec_next) begin
          tx_empty <= 1'b1; // R23
        end else if (wr_data && !finished) begin
          tx_empty <= 1'b0;
        end
        if (!dir_f && ev_byte_rx && !in_addr && !ev_arb_lost) begin
          rx_full <= 1'b1; // R23
        end else if ((rd_data || wr_data) && !finished) begin
          rx_full <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      finished <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        finished <= 1'b0; // R3
      end else if (!ctl[CTL_NO_STRETCH] && !ev_nack &&
                   ((ev_byte_rx && rx_full) ||
                    (ev_byte_due && tx_empty && !pec_next))) begin
        finished <= 1'b1; // R2 R4
      end else if (rd_data || wr_data ||
                   (dir_f && (ev_start_seen || ev_stop_seen))) begin
        finished <= 1'b0; // R3
      end
    end
  end

  // ****************************************
  // Status two flags
  // ****************************************
  logic master_f;
  logic busy_f;
  logic dual_f;
  logic host_f;
  logic dflt_f;
  logic gc_f;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_f <= 1'b0;
    end else if (ce) begin
      if (ev_stop_seen) begin
        busy_f <= 1'b0; // R15
      end else if (!scl_h || !sda_h) begin
        busy_f <= 1'b1; // R15
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      master_f <= 1'b0;
    end else if (ce) begin
      if (!en || ev_stop_seen || ev_arb_lost) begin
        master_f <= 1'b0; // R16
      end else if (ev_start_gen) begin
        master_f <= 1'b1; // R16
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dir_f <= 1'b0;
    end else if (ce) begin
      if (!en || ev_stop_seen || ev_start_seen || ev_arb_lost) begin
        dir_f <= 1'b0; // R14
      end else if (ev_addr_done || ev_addr_match) begin
        dir_f <= master_f ? !rw_bit : rw_bit; // R14
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dual_f <= 1'b0;
      host_f <= 1'b0;
      dflt_f <= 1'b0;
      gc_f <= 1'b0;
    end else if (ce) begin
      if (!en || ev_stop_seen || ev_start_seen) begin
        dual_f <= 1'b0; // R13
        host_f <= 1'b0;
        dflt_f <= 1'b0;
        gc_f <= 1'b0;
      end else if (ev_addr_match) begin
        dual_f <= match_kind == 3'h1; // R11
        gc_f <= match_kind == 3'h2 && ctl[CTL_GC_EN]; // R12
        dflt_f <= match_kind == 3'h3 && ctl[CTL_RESOLVE];
        host_f <= match_kind == 3'h4 && ctl[CTL_RESOLVE] && ctl[CTL_HOST_TYPE];
      end
    end
  end

  // ****************************************
  // SCL generator
  // ****************************************
  tsc_scl_e st;
  logic [16:0] cnt;
  logic [RISE_W-1:0] rcnt;
  logic [4:0] mul_hi;
  logic [4:0] mul_lo;
  logic [16:0] t_hi;
  logic [16:0] t_lo;
  always_comb begin
    if (!clk_ctl[CC_FAST]) begin
      mul_hi = MUL_ONE; // R17 R18
      mul_lo = MUL_ONE;
    end else if (!clk_ctl[CC_DUTY]) begin
      mul_hi = MUL_ONE;
      mul_lo = MUL_TWO;
    end else begin
      mul_hi = MUL_HIGH_DUTY;
      mul_lo = MUL_LOW_DUTY;
    end
    // Both operands widened first so the product never loses its top bits
    t_hi = {5'h00, clk_ctl[CC_DIV_W-1:0]} * {12'h000, mul_hi}; // R18
    t_lo = {5'h00, clk_ctl[CC_DIV_W-1:0]} * {12'h000, mul_lo};
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= TSC_IDLE;
      cnt <= '0;
      rcnt <= '0;
      scl_oe <= 1'b0;
    end else if (ce) begin
      case (st)
        TSC_IDLE: begin
          scl_oe <= 1'b0;
          if (en && scl_run) begin
            st <= TSC_LOW;
            cnt <= 17'h00001;
            scl_oe <= 1'b1;
          end
        end
        TSC_LOW: begin
          if (cnt >= t_lo) begin
            st <= TSC_RISE;
            rcnt <= '0;
            scl_oe <= 1'b0;
          end else begin
            cnt <= cnt + 17'h00001;
          end
        end
        TSC_RISE: begin
          // A stretching slave holds us here until SCL is high or rcnt reaches rise
          if (scl_h || rcnt >= rise) begin
            st <= TSC_HIGH; // R24 R21
            cnt <= 17'h00001;
          end else if (rcnt < rise) begin
            rcnt <= rcnt + 6'h01;
          end
        end
        TSC_HIGH: begin
          if (!scl_h && rcnt < rise) begin
            cnt <= 17'h00001; // R24
          end else if (cnt >= t_hi) begin
            st <= (en && scl_run) ? TSC_LOW : TSC_IDLE;
            cnt <= 17'h00001;
            scl_oe <= en && scl_run;
          end else begin
            cnt <= cnt + 17'h00001;
          end
        end
        default: st <= TSC_IDLE;
      endcase
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_out <= 1'b0;
      rdata <= '0;
      status_one_q <= '0;
      status_two_q <= '0;
    end else if (ce) begin
      scl_out <= 1'b0;
      status_one_q <= {8'h00, tx_empty, rx_full, 2'b00, header_f, finished, addr_f, start_f};
      status_two_q <= {ctl[CTL_PEC_EN] ? pec_value : 8'h00, // R10
                       dual_f, host_f, dflt_f, gc_f, 1'b0, dir_f, busy_f, master_f}; // R25
      if (rd) begin
        if (addr == OFS_STATUS_ONE) begin
          rdata <= {8'h00, tx_empty, rx_full, 2'b00, header_f, finished, addr_f, start_f};
        end else if (addr == OFS_STATUS_TWO) begin
          rdata <= {ctl[CTL_PEC_EN] ? pec_value : 8'h00,
                    dual_f, host_f, dflt_f, gc_f, 1'b0, dir_f, busy_f, master_f};
        end else if (addr == OFS_CLOCK_CONTROL) begin
          rdata <= clk_ctl;
        end else if (addr == OFS_RISE_TIME) begin
          rdata <= {10'h000, rise};
        end else if (addr == OFS_CONTROL) begin
          rdata <= {8'h00, ctl};
        end else begin
          rdata <= '0;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tsc_properties.sv
`default_nettype none
module tsc_checker
  import tsc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic [7:0] addr, // Register address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic sda_in, // SDA level
  input wire logic scl_oe, // SCL pulled low
  input wire logic scl_run, // Clock wanted
  input wire logic ev_start_gen, // Start made
  input wire logic ev_start_seen, // Start seen
  input wire logic ev_stop_seen, // Stop seen
  input wire logic ev_header_sent, // Header sent
  input wire logic ev_addr_done, // Master address acked
  input wire logic ev_addr_match, // Slave address match
  input wire logic [2:0] match_kind, // Match kind
  input wire logic rw_bit, // Address direction bit
  input wire logic ev_nack, // NACK
  input wire logic [15:0] status_one_q, // Status one
  input wire logic [15:0] status_two_q // Status two
);
  // ****************************************
  // Helper state
  // ****************************************
  logic [15:0] cc;
  logic [16:0] lo_cnt;
  logic [16:0] exp_lo;
  always_ff @(posedge clk) begin
    if (!nrst) cc <= RST_CLOCK_CONTROL;
    else if (wr && addr == OFS_CLOCK_CONTROL) cc <= wdata;
  end
  // Counts a whole low phase so its length is judged when SCL is let go
  always_ff @(posedge clk) begin
    if (!nrst) lo_cnt <= 17'h00000;
    else lo_cnt <= scl_oe ? lo_cnt + 17'h00001 : 17'h00000;
  end
  assign exp_lo = {5'h00, cc[11:0]} *
    (!cc[CC_FAST] ? 17'h00001 : cc[CC_DUTY] ? 17'h00010 : 17'h00002);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd_one; rd && addr == OFS_STATUS_ONE; endsequence
  sequence s_rd_two; rd && addr == OFS_STATUS_TWO && !ev_addr_match && !ev_addr_done; endsequence
  AST_ADDR_CLEAR: assert property (s_rd_one ##1 s_rd_two |->
    ##[1:2] !status_one_q[S1_ADDR])
    else $error("address flag kept after status reads");
  AST_START_SET: assert property (ev_start_gen |->
    ##[1:2] status_one_q[S1_START] && status_two_q[S2_MASTER])
    else $error("start or master flag missing");
  AST_HEADER_SET: assert property (ev_header_sent && !ev_nack |->
    ##[1:2] status_one_q[S1_HEADER])
    else $error("header flag missing");
  AST_ADDR_SET: assert property ((ev_addr_done || ev_addr_match) && !ev_nack |->
    ##[1:2] status_one_q[S1_ADDR])
    else $error("address flag missing");
  AST_DUAL_SET: assert property (ev_addr_match && match_kind == 3'h1 |->
    ##[1:2] status_two_q[S2_DUAL])
    else $error("dual flag missing");
  AST_DIR_SET: assert property (ev_addr_match && rw_bit && !ev_stop_seen && !ev_start_seen
    |-> ##[1:2] status_two_q[S2_DIR])
    else $error("direction flag missing");
  AST_KIND_CLEAR: assert property ((ev_stop_seen || ev_start_seen) && !ev_addr_match
    && !ev_addr_done |-> ##[1:2] status_two_q[7:4] == 4'h0 && !status_two_q[S2_DIR])
    else $error("kind flags kept after stop or restart");
  AST_MASTER_CLEAR: assert property (ev_stop_seen && !ev_start_gen |->
    ##[1:2] !status_two_q[S2_MASTER])
    else $error("master flag kept after stop");
  AST_BUSY_SET: assert property ((!sda_in)[*3] |-> ##[1:3] status_two_q[S2_BUSY])
    else $error("busy flag missing");
  AST_RESERVED: assert property (!status_two_q[3] && !status_one_q[5])
    else $error("reserved status bit set");
  AST_SCL_LOW: assert property ($fell(scl_oe) && $past(scl_run) |-> lo_cnt == exp_lo)
    else $error("SCL low phase length wrong");
endmodule
bind tsc_core tsc_checker chk_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .sda_in(sda_in), .scl_oe(scl_oe), .scl_run(scl_run), .ev_start_gen(ev_start_gen),
  .ev_start_seen(ev_start_seen), .ev_stop_seen(ev_stop_seen), .ev_header_sent(ev_header_sent),
  .ev_addr_done(ev_addr_done), .ev_addr_match(ev_addr_match), .match_kind(match_kind),
  .rw_bit(rw_bit), .ev_nack(ev_nack), .status_one_q(status_one_q), .status_two_q(status_two_q));
`default_nettype wire

//--- sim/tsc_bus_model.sv
`default_nettype none
module tsc_bus_model (
  input wire logic clk, // Clock
  input wire logic scl_oe, // Device pulls SCL low
  input wire logic sda_low, // Another party holds SDA low
  input wire logic [7:0] stretch, // Cycles a slave keeps SCL low after release
  output logic scl_in, // SCL line level
  output logic sda_in // SDA line level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] hold = 8'h00;
  always @(posedge clk) begin
    if (scl_oe) hold <= stretch;
    else if (hold != 8'h00) hold <= hold - 8'h01;
  end
  // Pull-ups: a released line reads high
  assign scl_in = !(scl_oe || hold != 8'h00);
  assign sda_in = !sda_low;
endmodule
`default_nettype wire

//--- sim/tb.sv
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb
  import tsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rw = 1'b0, pec_next = 1'b0;
  logic scl_run = 1'b0, sda_low = 1'b0;
  logic [7:0] addr = 8'h00, pec = 8'h00, stretch = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [9:0] ev = 10'h000;
  logic [2:0] kind = 3'h0;
  logic [15:0] rdata, s1, s2;
  logic scl_in, sda_in, scl_oe, scl_out, tx_empty, rx_full, finished;
  int n_errors = 0, checks_done = 0;
  always #10 clk = ~clk;
  tsc_core dut_u (.clk(clk), .nrst(nrst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .ev_start_gen(ev[0]), .ev_start_seen(ev[1]), .ev_stop_seen(ev[2]), .ev_arb_lost(ev[3]),
    .ev_header_sent(ev[4]), .ev_addr_done(ev[5]), .ev_addr_match(ev[6]), .match_kind(kind),
    .rw_bit(rw), .ev_byte_rx(ev[7]), .ev_byte_due(ev[8]), .ev_nack(ev[9]), .pec_next(pec_next),
    .pec_value(pec), .scl_run(scl_run), .tx_empty(tx_empty), .rx_full(rx_full),
    .finished(finished), .status_one_q(s1), .status_two_q(s2));
  tsc_bus_model bus_u (.clk(clk), .scl_oe(scl_oe), .sda_low(sda_low), .stretch(stretch),
    .scl_in(scl_in), .sda_in(sda_in));
  // ****************************************
  // Bus and event helpers
  // ****************************************
  task wr_r(input logic [7:0] a, input logic [15:0] d);
    wr <= 1'b1; addr <= a; wdata <= d; @(posedge clk); wr <= 1'b0; #1;
  endtask
  task rd_r(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    rd <= 1'b1; addr <= a; @(posedge clk); rd <= 1'b0; #1;
    `CHK(rdata & m, e)
  endtask
  task pulse(input int i);
    ev[i] <= 1'b1; @(posedge clk); ev <= 10'h000; #1;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wait_oe(input logic v);
    int n;
    n = 0;
    while (scl_oe !== v && n < 3000) begin @(posedge clk); #1; n++; end
    `CHK(scl_oe, v)
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    rd_r(OFS_STATUS_TWO, 16'hFFFF, 16'h0000);
    rd_r(OFS_CLOCK_CONTROL, 16'hFFFF, RST_CLOCK_CONTROL);
    rd_r(OFS_RISE_TIME, 16'hFFFF, 16'h0002);
    wr_r(OFS_CLOCK_CONTROL, 16'hFFFF);
    wr_r(OFS_RISE_TIME, 16'hFFFF);
    wr_r(8'h3C, 16'hFFFF);
    rd_r(OFS_CLOCK_CONTROL, 16'hFFFF, 16'hCFFF);
    rd_r(OFS_RISE_TIME, 16'hFFFF, 16'h003F);
    rd_r(8'h3C, 16'hFFFF, 16'h0000);
  endtask
  // Runs while disabled on purpose: busy must still track the bus
  task t_busy;
    sda_low <= 1'b1; idle(5);
    rd_r(OFS_STATUS_TWO, 16'h0002, 16'h0002);
    sda_low <= 1'b0; idle(3); pulse(2); idle(2);
    rd_r(OFS_STATUS_TWO, 16'h0002, 16'h0000);
  endtask
  task t_master;
    wr_r(OFS_CONTROL, 16'h0001); pulse(0); idle(2);
    rd_r(OFS_STATUS_ONE, 16'h000F, 16'h0001);
    wr_r(OFS_DATA, 16'h00F0); idle(2);
    rd_r(OFS_STATUS_ONE, 16'h0001, 16'h0000);
    rd_r(OFS_STATUS_TWO, 16'h0001, 16'h0001);
    pulse(4); idle(2);
    rd_r(OFS_STATUS_ONE, 16'h0008, 16'h0008);
    wr_r(OFS_DATA, 16'h00F1); idle(2);
    rd_r(OFS_STATUS_ONE, 16'h0008, 16'h0000);
    pulse(5); idle(2);
    rd_r(OFS_STATUS_ONE, 16'h0002, 16'h0002);
    rd_r(OFS_STATUS_TWO, 16'h0004, 16'h0004);
    idle(2);
    rd_r(OFS_STATUS_ONE, 16'h0002, 16'h0000);
    pulse(3); idle(2);
    rd_r(OFS_STATUS_TWO, 16'h0005, 16'h0000);
  endtask
  task t_slave;
    logic [3:0] kb [5] = '{4'h0, 4'h8, 4'h1, 4'h2, 4'h4};
    wr_r(OFS_CONTROL, 16'h0059);
    for (int k = 0; k < 5; k++) begin
      kind <= k[2:0]; rw <= 1'b1; pulse(6); idle(2);
      rd_r(OFS_STATUS_ONE, 16'h0002, 16'h0002);
      rd_r(OFS_STATUS_TWO, 16'h00F4, {8'h00, kb[k], 4'h4});
      pulse(k[0] ? 1 : 2); idle(2);
      rd_r(OFS_STATUS_TWO, 16'h00F4, 16'h0000);
    end
    wr_r(OFS_CONTROL, 16'h0001); kind <= 3'h2; pulse(6); idle(2);
    rd_r(OFS_STATUS_TWO, 16'h00F0, 16'h0000);
    pulse(2); rw <= 1'b0;
  endtask
  task t_finish;
    pulse(7); idle(2);
    `CHK(rx_full, 1'b1)
    `CHK(finished, 1'b0)
    pulse(7); idle(2);
    `CHK(finished, 1'b1)
    rd_r(OFS_STATUS_ONE, 16'h0004, 16'h0004);
    rd_r(OFS_DATA, 16'hFF00, 16'h0000); idle(2);
    `CHK(finished, 1'b0)
    // Slave read request puts us in transmit, so an empty register could finish
    wr_r(OFS_CONTROL, 16'h0021); pec <= 8'hA5; kind <= 3'h0; rw <= 1'b1;
    pulse(6); pulse(8); idle(1);
    `CHK(tx_empty, 1'b1)
    pec_next <= 1'b1; pulse(8); idle(2);
    `CHK(finished, 1'b0)
    rd_r(OFS_STATUS_TWO, 16'hFF00, 16'hA500);
    pec_next <= 1'b0; pulse(2); rw <= 1'b0; idle(2);
  endtask
  task t_scl(input logic [15:0] cc, input int lo, input int hi, input logic [7:0] st);
    int c, g;
    wr_r(OFS_CONTROL, 16'h0000); wr_r(OFS_CLOCK_CONTROL, cc);
    wr_r(OFS_RISE_TIME, 16'h0014); wr_r(OFS_CONTROL, 16'h0001);
    stretch <= st; scl_run <= 1'b1;
    wait_oe(1'b1); wait_oe(1'b0); wait_oe(1'b1);
    c = 0;
    while (scl_oe === 1'b1 && c < 3000) begin c++; @(posedge clk); #1; end
    `CHK(c, lo)
    g = 0;
    while (scl_oe !== 1'b1 && g < 3000) begin g++; @(posedge clk); #1; end
    `CHK(g >= hi + st && g <= hi + st + 26, 1'b1)
    scl_run <= 1'b0; stretch <= 8'h00; wait_oe(1'b0); idle(30);
  endtask
  task wrap_up;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1; @(posedge clk); #1;
    t_regs; t_busy; t_master; t_slave; t_finish;
    t_scl(16'h0004, 4, 4, 8'h00);
    t_scl(16'h8004, 8, 4, 8'h00);
    t_scl(16'hC001, 16, 9, 8'h06);
    wrap_up;
  end
  initial begin
    #1_000_000;
    n_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
